/* File: hw/pitr_regs.sv */
// command registers for phase placement, current trims and ov limit.
// assumes commands arrive on link_clk, telemetry on core_clk, and the
// stack strap is an asynchronous pin.
//
// What this block does
// - top nibble of the placement word reads zero and is read only
// - bits 11..8 hold a group identifier, any value 0..15
// - bits 7..4 hold phase positions per group, valid 1..4
// - bits 3..0 hold this device's position, below the group count
// - switching delay is 360 over group count times position
// - stack members refuse host writes to the placement word
// - write permission is fixed by the stack strap at power-on only
// - reported current is sensed current times gain trim plus offset sum, gain default one
// - restore rounds gain trim to nearest 1/64, capped at 1.984
// - offset trims outside -8 A..+7.9375 A are refused and flagged
// - each device keeps own trims, effective offset is the sum over phases below the group count
// - fine offset writes accepted in range, restore keeps stored grid
// - phase selector 0..3 reads and writes one phase only
// - all-phase offset write gives each phase total over phase count
// - all-phase offset read returns phase zero times phase count
// - ov threshold is always relative to the present voltage target
// - in absolute mode a new voltage target leaves the ov limit alone
// - ov detection runs right after reset, conversion on or off
// - ov fault action follows the configured response setting
// - placement sets delay between sync signal and internal oscillator
// - ov fault sets status byte, word and vout bits and alert in the same cycle
`timescale 1ns/1ps
`include "pitr_map.svh"

module pitr_regs
  import pitr_pkg::*;
(
  input wire logic core_clk, // block clock, 200 MHz
  input wire logic rstn, // synchronous reset, active low
  input wire logic link_clk, // host command clock
  input wire logic lreq_valid, // host command offered, link domain
  input wire pitr_req_type lreq, // host command fields
  output pitr_rsp_type lrsp_q, // answer fields, link domain
  output logic lrsp_valid_q, // answer strobe, one link cycle
  output logic lbusy_q, // command in flight, link domain
  input wire logic stack_strap, // pin: device is a stack member
  input wire logic nvm_restore, // restore trims to stored grid
  input wire logic clear_faults, // clears sticky flags
  input wire logic signed [15:0] sense_iout, // amps, 8 fraction bits
  input wire logic [15:0] vout_cmd, // present voltage target
  input wire logic vout_mode_abs, // limit word in absolute format
  input wire logic [15:0] vout_sense, // measured output voltage
  input wire logic conv_en, // output conversion enabled
  input wire logic [1:0] ov_response, // 00 ignore, 01/10 shut down
  output logic signed [15:0] report_iout_q, // trimmed current
  output logic signed [15:0] offset_share_q, // own offset sum
  output logic [8:0] phase_deg_q, // switching delay after sync
  output logic [7:0] group_id_q, // group of devices on one sync
  output logic write_locked_q, // placement word is read only
  output logic invalid_data_q, // sticky invalid data flag
  output logic ov_shutdown_q, // shut down by ov fault
  output pitr_ov_stat_type ov_stat_q // sticky ov status bits
);

  // ****************************************
  // linear format helpers
  // ****************************************
  // linear word to fixed point with 8 fraction bits
  function automatic logic signed [31:0] lin_fix(input logic [15:0] w);
    logic signed [5:0] sh;
    logic signed [31:0] m;
    sh = 6'($signed(w[15:11])) + 6'sd8;
    m = 32'($signed(w[10:0]));
    if (sh >= 0)
      lin_fix = m <<< sh;
    else
      lin_fix = m >>> (-sh);
  endfunction : lin_fix

  // fixed point to a linear word with the given exponent
  function automatic logic [15:0] fix_lin(input logic signed [31:0] f,
                                          input logic [4:0] e);
    logic signed [5:0] sh;
    sh = 6'sd8 + 6'($signed(e));
    fix_lin = {e, 11'(f >>> sh)};
  endfunction : fix_lin

  // ****************************************
  // link side: capture and answer
  // ****************************************
  logic l_rst1, l_rstn_q, l_ack1, l_ack2, l_ack_seen_q, lreq_tgl_q;
  pitr_lstate_type l_state_q;
  pitr_req_type req_q;
  logic c_ack_tgl_q;
  pitr_rsp_type c_rsp_q;

  // reset is from the core domain, so it is resynchronised here
  always_ff @(posedge link_clk)
  begin
    l_rst1 <= rstn;
    l_rstn_q <= l_rst1;
  end

  always_ff @(posedge link_clk)
  begin
    l_ack1 <= c_ack_tgl_q;
    l_ack2 <= l_ack1;
  end

  // one command in flight; the held fields are read by the core only
  // after the toggle crossing, so they are stable by then
  always_ff @(posedge link_clk)
  begin
    if (!l_rstn_q)
    begin
      l_state_q <= L_IDLE;
      req_q <= '0;
      lreq_tgl_q <= 1'b0;
      l_ack_seen_q <= 1'b0;
      lbusy_q <= 1'b0;
      lrsp_valid_q <= 1'b0;
      lrsp_q <= '0;
    end
    else
    begin
      lrsp_valid_q <= 1'b0;
      unique case (l_state_q)
        L_IDLE:
          if (lreq_valid)
          begin
            req_q <= lreq;
            lreq_tgl_q <= ~lreq_tgl_q;
            lbusy_q <= 1'b1;
            l_state_q <= L_WAIT;
          end
        L_WAIT:
          if (l_ack2 != l_ack_seen_q)
          begin
            l_ack_seen_q <= l_ack2;
            lrsp_q <= c_rsp_q;
            lrsp_valid_q <= 1'b1;
            lbusy_q <= 1'b0;
            l_state_q <= L_IDLE;
          end
      endcase
    end
  end

  // ****************************************
  // core side: request crossing and strap
  // ****************************************
  logic c_req1, c_req2, c_req_seen_q, c_evt;
  logic strap1, strap2, lock_taken_q;
  logic [1:0] pwr_cnt_q;

  always_ff @(posedge core_clk)
  begin
    c_req1 <= lreq_tgl_q;
    c_req2 <= c_req1;
    strap1 <= stack_strap;
    strap2 <= strap1;
  end

  // strap is caught once, after the synchroniser has filled
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      pwr_cnt_q <= 2'h0;
      lock_taken_q <= 1'b0;
      write_locked_q <= 1'b0;
    end
    else if (!lock_taken_q)
    begin
      pwr_cnt_q <= pwr_cnt_q + 2'h1;
      if (pwr_cnt_q == `PITR_PWR_WAIT)
      begin
        write_locked_q <= strap2;
        lock_taken_q <= 1'b1;
      end
    end
  end

  // commands wait until write permission is known
  assign c_evt = lock_taken_q && (c_req2 != c_req_seen_q);

  // ****************************************
  // command decode
  // ****************************************
  logic [15:0] il_q, gain_q, ov_q;
  logic [15:0] ofs_q [4];
  logic [3:0] ov_step_q;
  logic [3:0] ov_step_d;
  logic [3:0] il_num, il_ord;
  logic [1:0] psel;
  logic signed [31:0] wfix, ofs0_fix, pdiv, pfix [4];
  logic phase_ok, phase_all, ofs_ok, il_ok, ov_ok;
  logic [15:0] ov_ref;
  logic [`PITR_OV_STEPS-1:0] ov_fit;
  logic [2:0] nph;

  assign il_num = il_q[7:4];
  assign il_ord = il_q[3:0];
  assign nph = (il_num == 4'h0 || il_num > 4'h4) ? 3'd1 : il_num[2:0];
  assign psel = req_q.phase[1:0];
  assign phase_all = (req_q.phase == `PITR_PHASE_ALL);
  assign phase_ok = phase_all || (req_q.phase <= `PITR_PHASE_LAST);
  assign wfix = lin_fix(req_q.wdata);
  assign ofs0_fix = lin_fix(ofs_q[0]);

  // per-phase share of an all-phase total; thirds by reciprocal
  always_comb
  begin
    unique case (nph)
      3'd2: pdiv = wfix >>> 1;
      3'd3: pdiv = 32'((64'(wfix) * 64'sd683) >>> 11);
      3'd4: pdiv = wfix >>> 2;
      default: pdiv = wfix;
    endcase
  end

  // range is checked on what each phase will hold
  assign ofs_ok = phase_ok && (phase_all ?
    (pdiv >= `PITR_OFS_MIN_FIX && pdiv <= `PITR_OFS_MAX_FIX) :
    (wfix >= `PITR_OFS_MIN_FIX && wfix <= `PITR_OFS_MAX_FIX));

  // group count 1..4 and position below it
  assign il_ok = req_q.wdata[15:12] == 4'h0 &&
    req_q.wdata[7:4] >= 4'h1 && req_q.wdata[7:4] <= 4'h4 &&
    req_q.wdata[3:0] < req_q.wdata[7:4];

  // ov limit maps up to the next 2.5 % step from 105 %; relative words
  // use a fixed unity so both formats end as a ratio of the target
  assign ov_ref = vout_mode_abs ? vout_cmd : `PITR_REL_UNITY;
  genvar gi;
  generate
    for (gi = 0; gi < `PITR_OV_STEPS; gi++)
    begin : g_ov_fit
      assign ov_fit[gi] = 32'(ov_ref) * 32'(`PITR_OV_BASE + gi) >=
        32'(req_q.wdata) * 32'(`PITR_OV_DIV);
    end
  endgenerate

  always_comb
  begin
    ov_step_d = 4'h0;
    for (int i = `PITR_OV_STEPS - 1; i >= 0; i--)
      if (ov_fit[i])
        ov_step_d = 4'(i);
  end
  assign ov_ok = |ov_fit;

  // ****************************************
  // register writes, reads and restore
  // ****************************************
  logic bad_cmd;

  always_comb
  begin
    bad_cmd = 1'b0;
    if (req_q.code == `PITR_CMD_PHASE_POSITION_CONFIG)
      bad_cmd = req_q.wr && (write_locked_q || !il_ok);
    else if (req_q.code == `PITR_CMD_OFFSET)
      bad_cmd = req_q.wr ? !ofs_ok : !phase_ok;
    else if (req_q.code == `PITR_CMD_OV_LIMIT)
      bad_cmd = req_q.wr && !ov_ok;
    else if (req_q.code != `PITR_CMD_GAIN)
      bad_cmd = 1'b1;
  end

  // restore rounds to the grid that nonvolatile storage can hold
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      il_q <= `PITR_IL_RST;
      gain_q <= `PITR_GAIN_RST;
      ov_q <= `PITR_OV_RST;
      // step must match the reset limit word (115 % of target)
      ov_step_q <= `PITR_OV_STEP_RST;
    end
    else if (nvm_restore)
    begin
      if (lin_fix(gain_q) + 32'sd2 >= 32'sd512)
        gain_q <= {`PITR_EXP_64TH, `PITR_GAIN_MAX_MAN};
      else if (lin_fix(gain_q) < 32'sd0)
        gain_q <= {`PITR_EXP_64TH, 11'h000};
      else
        gain_q <= fix_lin(lin_fix(gain_q) + 32'sd2, `PITR_EXP_64TH);
    end
    else if (c_evt && req_q.wr && !bad_cmd)
    begin
      unique case (req_q.code)
        `PITR_CMD_PHASE_POSITION_CONFIG: il_q <= {4'h0, req_q.wdata[11:0]};
        `PITR_CMD_GAIN: gain_q <= req_q.wdata;
        `PITR_CMD_OV_LIMIT:
        begin
          ov_q <= req_q.wdata;
          ov_step_q <= ov_step_d;
        end
        default: ;
      endcase
    end
  end

  // per-phase offsets; fine writes kept as written during operation
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_phase
      assign pfix[gi] = lin_fix(ofs_q[gi]);
      always_ff @(posedge core_clk)
      begin
        if (!rstn)
          ofs_q[gi] <= `PITR_OFS_RST;
        else if (nvm_restore)
          ofs_q[gi] <= fix_lin(pfix[gi] + 32'sd8, `PITR_EXP_16TH);
        else if (c_evt && req_q.wr && !bad_cmd &&
                 req_q.code == `PITR_CMD_OFFSET)
        begin
          if (phase_all)
            ofs_q[gi] <= fix_lin(pdiv, `PITR_EXP_128TH);
          else if (psel == 2'(gi))
            ofs_q[gi] <= req_q.wdata;
        end
      end
    end
  endgenerate

  // answer and handshake back to the link side
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      c_req_seen_q <= 1'b0;
      c_ack_tgl_q <= 1'b0;
      c_rsp_q <= '0;
    end
    else if (c_evt)
    begin
      c_req_seen_q <= c_req2;
      c_ack_tgl_q <= ~c_ack_tgl_q;
      c_rsp_q.err <= bad_cmd;
      c_rsp_q.rdata <= 16'h0000;
      if (!req_q.wr && !bad_cmd)
      begin
        unique case (req_q.code)
          `PITR_CMD_PHASE_POSITION_CONFIG: c_rsp_q.rdata <= {4'h0, il_q[11:0]};
          `PITR_CMD_GAIN: c_rsp_q.rdata <= gain_q;
          `PITR_CMD_OV_LIMIT: c_rsp_q.rdata <= ov_q;
          default:
            c_rsp_q.rdata <= phase_all ?
              fix_lin(ofs0_fix * 32'(nph), `PITR_EXP_32ND) :
              ofs_q[psel];
        endcase
      end
    end
  end

  // invalid data is sticky; a new fault wins over a clear
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      invalid_data_q <= 1'b0;
    else if (c_evt && bad_cmd)
      invalid_data_q <= 1'b1;
    else if (clear_faults)
      invalid_data_q <= 1'b0;
  end

  // ****************************************
  // phase placement and current telemetry
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      phase_deg_q <= 9'd0;
      group_id_q <= 8'h00;
    end
    else
    begin
      group_id_q <= {4'h0, il_q[11:8]};
      unique case (il_num)
        4'h2: phase_deg_q <= 9'(il_ord * 9'd180);
        4'h3: phase_deg_q <= 9'(il_ord * 9'd120);
        4'h4: phase_deg_q <= 9'(il_ord * 9'd90);
        default: phase_deg_q <= 9'd0;
      endcase
    end
  end

  // only phases present in the group count toward the sum
  logic signed [31:0] ofs_sum;
  always_comb
  begin
    ofs_sum = 32'sd0;
    for (int i = 0; i < 4; i++)
      if (3'(i) < nph)
        ofs_sum = ofs_sum + pfix[i];
  end

  logic signed [47:0] gprod;
  assign gprod = 48'(sense_iout) * 48'(lin_fix(gain_q));

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      report_iout_q <= 16'sh0000;
      offset_share_q <= 16'sh0000;
    end
    else
    begin
      report_iout_q <= 16'(gprod >>> 8) + ofs_sum[15:0];
      offset_share_q <= ofs_sum[15:0];
    end
  end

  // ****************************************
  // overvoltage detection and response
  // ****************************************
  logic [3:0] ov_keff;
  logic ov_trip;

  // with conversion off only the coarse 10 % grid exists
  assign ov_keff = conv_en ? ov_step_q :
    4'((((ov_step_q + 4'h1) >> 2) << 2) + 4'h2);
  // compared against the live target, whatever the stored format
  assign ov_trip = 32'(vout_sense) * 32'(`PITR_OV_DIV) >
    32'(vout_cmd) * (32'(`PITR_OV_BASE) + 32'(ov_keff));

  // status is sticky; a new trip wins over a clear
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      ov_stat_q <= '0;
      ov_shutdown_q <= 1'b0;
    end
    else if (ov_trip)
    begin
      ov_stat_q <= '1;
      if (ov_response == 2'b01 || ov_response == 2'b10)
        ov_shutdown_q <= 1'b1;
    end
    else if (clear_faults)
    begin
      ov_stat_q <= '0;
      ov_shutdown_q <= 1'b0;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_top_nibble: assert property (il_q[15:12] == 4'h0)
    else $error("placement word top nibble not zero");
  a_quarter_step: assert property (il_num == 4'h4 && il_ord == 4'h3 |=>
    phase_deg_q == 9'd270)
    else $error("four-phase position 3 not at 270");
  a_locked_write: assert property (c_evt && write_locked_q && req_q.wr &&
    req_q.code == `PITR_CMD_PHASE_POSITION_CONFIG |=> $stable(il_q) && c_rsp_q.err)
    else $error("locked placement word was written");
  a_lock_frozen: assert property (lock_taken_q |=> $stable(write_locked_q))
    else $error("write permission changed after power-on");
  a_gain_round: assert property (nvm_restore |=>
    gain_q[15:11] == `PITR_EXP_64TH &&
    gain_q[10:0] <= `PITR_GAIN_MAX_MAN)
    else $error("restored gain not on 1/64 grid");
  a_offset_range: assert property (c_evt && req_q.wr && !phase_all &&
    req_q.code == `PITR_CMD_OFFSET && wfix > `PITR_OFS_MAX_FIX |=>
    $stable(ofs_q[psel]) ##1 invalid_data_q)
    else $error("out of range offset accepted");
  a_all_read: assert property (c_evt && !req_q.wr && phase_all &&
    req_q.code == `PITR_CMD_OFFSET |=> c_ack_tgl_q != $past(c_ack_tgl_q)
    && !c_rsp_q.err)
    else $error("all-phase offset read failed");
  a_ov_status: assert property (ov_trip |=> ov_stat_q == 4'hF)
    else $error("ov trip did not set status");
  a_ov_ignore: assert property (ov_trip && ov_response == 2'b00 &&
    !ov_shutdown_q |=> !ov_shutdown_q)
    else $error("ignore response shut down");

  c_write_il: cover property (c_evt && req_q.wr &&
    req_q.code == `PITR_CMD_PHASE_POSITION_CONFIG && !bad_cmd);
  c_all_write: cover property (c_evt && req_q.wr && phase_all && !bad_cmd);
  c_ov_shut: cover property (ov_trip && ov_response == 2'b01);

endmodule : pitr_regs

/* File: inc/pitr_map.svh */
// command codes, field positions, reset values and limits of the
// phase_position_config, current trim and overvoltage command registers.
// assumes it is included by the design package users only once.
`ifndef PITR_MAP_SVH
`define PITR_MAP_SVH

// ****************************************
// command codes
// ****************************************
`define PITR_CMD_PHASE_POSITION_CONFIG 8'h37
`define PITR_CMD_GAIN 8'h38
`define PITR_CMD_OFFSET 8'h39
`define PITR_CMD_OV_LIMIT 8'h40
`define PITR_PHASE_ALL 8'hFF
`define PITR_PHASE_LAST 8'h03

// ****************************************
// field positions and reset values
// ****************************************
`define PITR_IL_GROUP_LSB 8
`define PITR_IL_NUM_LSB 4
`define PITR_LIN_EXP_LSB 11
`define PITR_IL_RST 16'h0010
`define PITR_GAIN_RST 16'hC880
`define PITR_OFS_RST 16'hE000
`define PITR_OV_RST 16'h1266
`define PITR_OV_STEP_RST 4'h4
`define PITR_EXP_64TH 5'h1A
`define PITR_EXP_16TH 5'h1C
`define PITR_EXP_128TH 5'h19
`define PITR_EXP_32ND 5'h1B
`define PITR_GAIN_MAX_MAN 11'h007F

// ****************************************
// limits (offset in amps with 8 fraction bits)
// ****************************************
`define PITR_OFS_MIN_FIX (-32'sd2048)
`define PITR_OFS_MAX_FIX 32'sd2032
`define PITR_OV_STEPS 15
`define PITR_OV_BASE 42
`define PITR_OV_DIV 40
`define PITR_REL_UNITY 16'h1000
`define PITR_PWR_WAIT 2'h3

`endif

/* File: inc/pitr_pkg.sv */
// types shared by the command register block and its users.
// assumes the map header carries every numeric constant.
package pitr_pkg;

  // one command from the host, held stable across the crossing
  typedef struct packed {
    logic wr;
    logic [7:0] code;
    logic [15:0] wdata;
    logic [7:0] phase;
  } pitr_req_type;

  // answer to one command
  typedef struct packed {
    logic err;
    logic [15:0] rdata;
  } pitr_rsp_type;

  // overvoltage status bits as they leave the block
  typedef struct packed {
    logic byte_ov;
    logic word_vout;
    logic overvoltage_limit_value;
    logic alert;
  } pitr_ov_stat_type;

  typedef enum logic [0:0] {L_IDLE, L_WAIT} pitr_lstate_type;

endpackage : pitr_pkg

/* File: tb/pitr_host.sv */
// host model for the command port: one word command at a time.
// assumes commands are offered only while the block is idle.
`timescale 1ns/1ps

module pitr_host
  import pitr_pkg::*;
(
  input wire logic link_clk, // command clock
  output logic lreq_valid, // command offered
  output pitr_req_type lreq, // command fields
  input wire pitr_rsp_type lrsp_q, // answer fields
  input wire logic lrsp_valid_q, // answer strobe
  input wire logic lbusy_q // command in flight
);

  // ********************
  // idle lines at time zero
  // ********************
  initial
  begin
    lreq_valid = 1'b0;
    lreq = '0;
  end

  // word write or word read; fields scrambled once taken, so a block
  // that samples late sees garbage rather than a lucky stale value
  task automatic xfer(input logic wr, input logic [7:0] code,
    input logic [15:0] wd, input logic [7:0] ph,
    output pitr_rsp_type rsp, output logic ok);
    int n;
    ok = 1'b0;
    rsp = '0;
    @(posedge link_clk);
    lreq_valid <= 1'b1;
    lreq <= '{wr: wr, code: code, wdata: wd, phase: ph};
    @(posedge link_clk);
    lreq_valid <= 1'b0;
    lreq <= ~lreq;
    for (n = 0; n < 40 && !ok; n++)
    begin
      @(posedge link_clk);
      #1;
      if (lrsp_valid_q === 1'b1)
      begin
        ok = 1'b1;
        rsp = lrsp_q;
      end
    end
  endtask : xfer

endmodule : pitr_host

/* File: tb/tb_pmbus_phase_position_config_trim_ov_regs.sv */
// bench for the command register block: host commands and telemetry.
// assumes the host model drives the link port and answers arrive bounded.
`timescale 1ns/1ps

module tb_pmbus_phase_position_config_trim_ov_regs
  import pitr_pkg::*;
;
  logic core_clk, link_clk, rstn, lreq_valid, lrsp_valid_q, lbusy_q;
  logic stack_strap, nvm_restore, clear_faults, vout_mode_abs, conv_en;
  logic write_locked_q, invalid_data_q, ov_shutdown_q;
  logic [1:0] ov_response;
  logic [15:0] vout_cmd, vout_sense;
  logic signed [15:0] sense_iout, report_iout_q, offset_share_q;
  logic [8:0] phase_deg_q;
  logic [7:0] group_id_q;
  pitr_req_type lreq;
  pitr_rsp_type lrsp_q, r;
  pitr_ov_stat_type ov_stat_q;
  int bad_count = 0;
  int n_checks = 0;
  logic [15:0] il_w [6] = '{16'h0F21, 16'h0F31, 16'h0F32, 16'h0F41,
    16'h0010, 16'h0A43};
  logic [8:0] il_d [6] = '{9'h0B4, 9'h078, 9'h0F0, 9'h05A, 9'h000, 9'h10E};
  logic [15:0] il_bad [4] = '{16'h1A43, 16'h0A53, 16'h0A44, 16'h0A03};

  // ********************
  // clocks: link clock free running, unrelated in phase
  // ********************
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #40 link_clk = ~link_clk;
  end

  pitr_regs DUT (.core_clk(core_clk), .rstn(rstn), .link_clk(link_clk),
    .lreq_valid(lreq_valid), .lreq(lreq), .lrsp_q(lrsp_q),
    .lrsp_valid_q(lrsp_valid_q), .lbusy_q(lbusy_q),
    .stack_strap(stack_strap), .nvm_restore(nvm_restore),
    .clear_faults(clear_faults), .sense_iout(sense_iout),
    .vout_cmd(vout_cmd), .vout_mode_abs(vout_mode_abs),
    .vout_sense(vout_sense), .conv_en(conv_en), .ov_response(ov_response),
    .report_iout_q(report_iout_q), .offset_share_q(offset_share_q),
    .phase_deg_q(phase_deg_q), .group_id_q(group_id_q),
    .write_locked_q(write_locked_q), .invalid_data_q(invalid_data_q),
    .ov_shutdown_q(ov_shutdown_q), .ov_stat_q(ov_stat_q));

  pitr_host host (.link_clk(link_clk), .lreq_valid(lreq_valid),
    .lreq(lreq), .lrsp_q(lrsp_q), .lrsp_valid_q(lrsp_valid_q),
    .lbusy_q(lbusy_q));

  // ********************
  // shared tasks
  // ********************
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one host command; a missing answer ends the run
  task automatic cmd(input logic wr, input logic [7:0] code,
    input logic [15:0] wd, input logic [7:0] ph, input logic err);
    logic ok;
    host.xfer(wr, code, wd, ph, r, ok);
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("[FAIL] answer timeout");
      report_and_stop();
    end
    check("err", {15'h0000, r.err}, {15'h0000, err});
    check("busy", {15'h0000, lbusy_q}, 16'h0000);
  endtask : cmd

  task automatic rd(input logic [7:0] code, input logic [7:0] ph,
    input logic [15:0] exp);
    cmd(1'b0, code, 16'h0000, ph, 1'b0);
    check("rdata", r.rdata, exp);
  endtask : rd

  // wait for core telemetry to settle, then sample off the edge
  task automatic settle();
    repeat (4) @(posedge core_clk);
    #1;
  endtask : settle

  task automatic pulse_clear();
    @(posedge core_clk);
    clear_faults <= 1'b1;
    @(posedge core_clk);
    clear_faults <= 1'b0;
  endtask : pulse_clear

  task automatic do_reset();
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (64) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge link_clk);
    settle();
  endtask : do_reset

  // ********************
  // main sequence
  // ********************
  initial
  begin
    rstn = 1'b0;
    stack_strap = 1'b0;
    nvm_restore = 1'b0;
    clear_faults = 1'b0;
    sense_iout = 16'h0100;
    vout_cmd = 16'h03E8;
    vout_mode_abs = 1'b0;
    vout_sense = 16'h0000;
    conv_en = 1'b1;
    ov_response = 2'b00;
    do_reset();
    check("locked", {15'h0000, write_locked_q}, 16'h0000);
    rd(8'h37, 8'h00, 16'h0010);
    rd(8'h38, 8'h00, 16'hC880);
    rd(8'h39, 8'h00, 16'hE000);
    rd(8'h40, 8'h00, 16'h1266);
    check("iout", report_iout_q, 16'h0100);
    // six placements from the supported table, each group count 1..4
    for (int i = 0; i < 6; i++)
    begin
      cmd(1'b1, 8'h37, il_w[i], 8'h00, 1'b0);
      settle();
      check("deg", {7'h00, phase_deg_q}, {7'h00, il_d[i]});
      check("grp", {8'h00, group_id_q}, {12'h000, il_w[i][11:8]});
      rd(8'h37, 8'h00, il_w[i]);
    end
    // bad fields are refused and leave the word alone
    for (int i = 0; i < 4; i++)
    begin
      cmd(1'b1, 8'h37, il_bad[i], 8'h00, 1'b1);
      rd(8'h37, 8'h00, 16'h0A43);
    end
    cmd(1'b0, 8'h41, 16'h0000, 8'h00, 1'b1);
    check("inval", {15'h0000, invalid_data_q}, 16'h0001);
    // gain trim, then restore capping 2.0 down to 127/64
    cmd(1'b1, 8'h38, 16'hC900, 8'h00, 1'b0);
    settle();
    check("iout", report_iout_q, 16'h0200);
    @(posedge core_clk);
    sense_iout <= 16'h2000;
    nvm_restore <= 1'b1;
    @(posedge core_clk);
    nvm_restore <= 1'b0;
    settle();
    check("iout", report_iout_q, 16'h3F80);
    // offset trims per phase and for all four phases
    cmd(1'b1, 8'h39, 16'hE010, 8'h01, 1'b0);
    rd(8'h39, 8'h01, 16'hE010);
    rd(8'h39, 8'h00, 16'hE000);
    settle();
    check("share", offset_share_q, 16'h0100);
    cmd(1'b1, 8'h39, 16'hE040, 8'hFF, 1'b0);
    rd(8'h39, 8'hFF, 16'hD880);
    rd(8'h39, 8'h02, 16'hC880);
    settle();
    check("share", offset_share_q, 16'h0400);
    cmd(1'b1, 8'h39, 16'hE080, 8'h00, 1'b1);
    cmd(1'b1, 8'h39, 16'hE780, 8'h00, 1'b0);
    cmd(1'b1, 8'h39, 16'hE07F, 8'h03, 1'b0);
    cmd(1'b1, 8'h39, 16'hE010, 8'h04, 1'b1);
    settle();
    check("share", offset_share_q, 16'h01F0);
    // ov threshold at 115 percent of the target, response ignore then shut down
    @(posedge core_clk);
    vout_sense <= 16'h047E;
    settle();
    check("ov", {12'h000, ov_stat_q}, 16'h0000);
    @(posedge core_clk);
    vout_sense <= 16'h047F;
    settle();
    check("ov", {12'h000, ov_stat_q}, 16'h000F);
    check("shut", {15'h0000, ov_shutdown_q}, 16'h0000);
    @(posedge core_clk);
    vout_sense <= 16'h0000;
    ov_response <= 2'b01;
    pulse_clear();
    settle();
    check("ov", {12'h000, ov_stat_q}, 16'h0000);
    @(posedge core_clk);
    vout_sense <= 16'h047F;
    settle();
    check("shut", {15'h0000, ov_shutdown_q}, 16'h0001);
    // absolute limit kept when the target moves, trip follows target
    @(posedge core_clk);
    vout_sense <= 16'h0000;
    vout_mode_abs <= 1'b1;
    pulse_clear();
    cmd(1'b1, 8'h40, 16'h05DC, 8'h00, 1'b1);
    cmd(1'b1, 8'h40, 16'h044C, 8'h00, 1'b0);
    @(posedge core_clk);
    vout_cmd <= 16'h07D0;
    rd(8'h40, 8'h00, 16'h044C);
    @(posedge core_clk);
    vout_sense <= 16'h0898;
    settle();
    check("ov", {12'h000, ov_stat_q}, 16'h0000);
    @(posedge core_clk);
    vout_sense <= 16'h0899;
    settle();
    check("ov", {12'h000, ov_stat_q}, 16'h000F);
    // stack member at power-on: placement locked, ov armed, no conversion
    @(posedge core_clk);
    stack_strap <= 1'b1;
    conv_en <= 1'b0;
    vout_mode_abs <= 1'b0;
    vout_cmd <= 16'h03E8;
    vout_sense <= 16'h05DC;
    ov_response <= 2'b00;
    do_reset();
    check("ov", {12'h000, ov_stat_q}, 16'h000F);
    @(posedge core_clk);
    stack_strap <= 1'b0;
    cmd(1'b1, 8'h37, 16'h0021, 8'h00, 1'b1);
    check("locked", {15'h0000, write_locked_q}, 16'h0001);
    rd(8'h37, 8'h00, 16'h0010);
    report_and_stop();
  end

endmodule : tb_pmbus_phase_position_config_trim_ov_regs
